// ==== hw/xlc_pkg.sv ====
/*
 * Constants and types shared by the translation lookaside cache:
 * geometry, address bit positions, cache policy codes and the entry layout.
 * Assumes a 32-bit logical and physical address and page sizes of 4 or 8 Kbytes.
 */
package xlc_pkg;

    // Geometry
    localparam int XLC_WAYS = 4;
    localparam int XLC_SETS = 16;
    localparam int XLC_ENTRIES = 64;
    localparam int XLC_WAY_W = 2;
    localparam int XLC_IDX_W = 4;
    localparam int XLC_ENT_W = 6;

    // Address bit positions
    localparam int XLC_LA_W = 32;
    localparam int XLC_TAG_LSB = 16;
    localparam int XLC_TAG_W = 16;
    localparam int XLC_IDX_LSB_4K = 12;
    localparam int XLC_IDX_LSB_8K = 13;
    localparam int XLC_PA_LSB = 12;
    localparam int XLC_PA_W = 20;

    // Cache policy field codes
    localparam logic [1:0] XLC_CM_WRITE_THROUGH = 2'h0;
    localparam logic [1:0] XLC_CM_COPYBACK = 2'h1;
    localparam logic [1:0] XLC_CM_NC_SERIAL = 2'h2;
    localparam logic [1:0] XLC_CM_NONCACHE = 2'h3;

    // Replacement counter
    localparam logic [1:0] XLC_CTR_MAX = 2'h3;
    localparam logic [1:0] XLC_CTR_RESET = 2'h0;

    typedef struct packed {
        logic valid;
        logic global_pg;
        logic privilege_tag_bit;
        logic super_only;
        logic write_prot;
        logic modified;
        logic resident;
        logic [1:0] cache_policy_field;
        logic [1:0] user_attr;
        logic [XLC_TAG_W-1:0] tag;
        logic [XLC_PA_W-1:0] phys;
    } xlc_entry_t;

    typedef xlc_entry_t [XLC_WAYS-1:0] xlc_set_t;

    typedef enum logic {XLC_IDLE, XLC_SEARCH} xlc_state_t;

endpackage : xlc_pkg

// ==== hw/xlc_tag_match.sv ====
/*
 * Tag comparison across the four ways of one set.
 * Assumes the caller presents the selected set; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module xlc_tag_match (
    // Indexed set
    input wire xlc_pkg::xlc_set_t ways_i,
    // Compare key
    input wire logic [xlc_pkg::XLC_TAG_W-1:0] tag_i,
    input wire logic priv_i,
    input wire logic page_8k_i,
    // Result
    output logic [xlc_pkg::XLC_WAYS-1:0] match_o,
    output logic [xlc_pkg::XLC_WAY_W-1:0] way_o
);
    import xlc_pkg::*;

    logic [XLC_TAG_W-1:0] tag_mask;

    // Bit 16 of the tag only counts for small pages
    assign tag_mask = page_8k_i ? {{(XLC_TAG_W-1){1'b1}}, 1'b0} : {XLC_TAG_W{1'b1}}; // RQ5 RQ16

    genvar g;
    generate
        for (g = 0; g < XLC_WAYS; g++) begin : g_way
            assign match_o[g] = ways_i[g].valid
                && (ways_i[g].privilege_tag_bit == priv_i)
                && (((ways_i[g].tag ^ tag_i) & tag_mask) == '0); // RQ3 RQ14
        end
    endgenerate

    always_comb begin
        way_o = '0;
        for (int i = XLC_WAYS - 1; i >= 0; i--) begin
            if (match_o[i]) begin
                way_o = XLC_WAY_W'(i);
            end
        end
    end

endmodule : xlc_tag_match

`default_nettype wire

// ==== hw/xlc_victim.sv ====
/*
 * Way selection for a new translation: first invalid way, else counter.
 * Assumes the counter is advanced by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module xlc_victim (
    // Set state
    input wire logic [xlc_pkg::XLC_WAYS-1:0] valid_i,
    input wire logic [xlc_pkg::XLC_WAY_W-1:0] ctr_i,
    // Choice
    output logic [xlc_pkg::XLC_WAY_W-1:0] way_o
);
    import xlc_pkg::*;

    always_comb begin
        way_o = ctr_i; // RQ19
        for (int i = XLC_WAYS - 1; i >= 0; i--) begin
            if (!valid_i[i]) begin
                way_o = XLC_WAY_W'(i); // RQ18
            end
        end
    end

endmodule : xlc_victim

`default_nettype wire

// ==== hw/xlc_cache.sv ====
/*
 * Translation lookaside cache of a paged memory unit, with protection checks.
 * Assumes a table-search engine that answers each search request with one
 * done pulse, and a memory unit that retries after a miss or refused write.
 */
// Notes on behaviour
// (RQ1) Four-way set associative store of 64 page translations with status.
// (RQ2) Policy field: 00 write-through, 01 copyback, 10 serialized, 11 noncachable.
// (RQ3) Privilege tag bit stored per entry, set for supervisor, part of compare.
// (RQ4) Global entries survive flushes restricted to nonglobal entries.
// (RQ5) Full tag compare for 4K pages; tag LSB ignored for 8K pages.
// (RQ6) Write to entry with modified clear suspends, searches, rewrites entry, proceeds.
// (RQ7) Resident set only if search met no nonresident page or transfer error.
// (RQ8) User search hitting supervisor-only page makes such entry; retry faults.
// (RQ9) User attribute bits pass unchanged to outputs on external bus transfers.
// (RQ10) Valid set on load, cleared by any matching single or full flush; the code ignores a flush that arrives in XLC_SEARCH.
// (RQ11) Entry write-protected if any walked descriptor was; write hit faults immediately.
// (RQ12) Write protection binds supervisor writes too; table-level protection covers pages.
// (RQ13) Set index: address bits 16..13 for 8K pages, 15..12 for 4K.
// (RQ14) Upper address and privilege compared per way; valid match selects entry.
// (RQ15) Miss aborts access, starts search, stores translation for retry.
// (RQ16) 4K: physical bit 12 from entry, bit 16 compared; 8K: bit 12 passes.
// (RQ17) Software disables translation before page size change, flushes before re-enable.
// (RQ18) Fill an invalid way if any; pseudo-random choice only for full sets.
// (RQ19) Two-bit counter advances each access, picks victim on full-set miss; the code advances it only on accesses taken with translate_en_i set.
// (RQ20) Lookup runs alongside cache indexing, adding no extra access latency.
// (RQ21) Supervisor searches use supervisor root, except alternate alt_space_move; users use user root.
// (RQ22) Replacement counter wraps from three to zero.
`timescale 1ns/1ps
`default_nettype none

module xlc_cache (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Configuration
    input wire logic translate_en_i,
    input wire logic page_8k_i,
    input wire logic [xlc_pkg::XLC_LA_W-1:0] supervisor_root_ptr_i,
    input wire logic [xlc_pkg::XLC_LA_W-1:0] user_root_ptr_i,
    // Access request from the memory unit
    input wire logic req_i,
    input wire logic [xlc_pkg::XLC_LA_W-1:0] la_i,
    input wire logic super_i,
    input wire logic write_i,
    input wire logic alt_space_move_i,
    input wire logic ext_bus_i,
    // Flush requests
    input wire logic translation_flush_op_i,
    input wire logic flush_all_op_i,
    input wire logic flush_nonglobal_i,
    input wire logic [xlc_pkg::XLC_LA_W-1:0] flush_la_i,
    input wire logic flush_super_i,
    // Table search answer
    input wire logic walk_done_i,
    input wire logic [xlc_pkg::XLC_PA_W-1:0] walk_phys_i,
    input wire logic [1:0] walk_cache_policy_field_i,
    input wire logic [1:0] walk_user_attr_i,
    input wire logic walk_global_i,
    input wire logic walk_super_only_i,
    input wire logic walk_write_prot_i,
    input wire logic walk_modified_i,
    input wire logic walk_nonresident_i,
    input wire logic walk_tea_i,
    // Access answer
    output logic ready_o,
    output logic done_o,
    output logic miss_o,
    output logic access_error_o,
    output logic bus_error_o,
    output logic retry_o,
    output logic [xlc_pkg::XLC_PA_W-1:0] phys_addr_o,
    output logic [1:0] cache_policy_field_o,
    output logic user_attr_out_zero_o,
    output logic user_attr_out_one_o,
    // Table search request
    output logic search_req_o,
    output logic [xlc_pkg::XLC_LA_W-1:0] search_root_o,
    output logic [xlc_pkg::XLC_LA_W-1:0] search_la_o,
    output logic search_super_o,
    output logic search_write_o
);
    import xlc_pkg::*;

    typedef struct packed {
        xlc_state_t state;
        xlc_entry_t [XLC_ENTRIES-1:0] ent; // RQ1
        logic [XLC_WAY_W-1:0] ctr;
        logic [XLC_ENT_W-1:0] p_slot;
        logic p_super;
        logic ready;
        logic done;
        logic miss;
        logic acc_err;
        logic bus_err;
        logic retry;
        logic [XLC_PA_W-1:0] pa;
        logic [1:0] cm;
        logic [1:0] upa;
        logic srch;
        logic [XLC_LA_W-1:0] s_root;
        logic [XLC_LA_W-1:0] s_la;
        logic s_super;
        logic s_write;
    } xlc_state_reg_t;

    xlc_state_reg_t cur_ff;
    xlc_state_reg_t nxt_cur;

    ////////////////////////////////////////////////////////////////////////
    // Set selection and tag compare

    logic [XLC_IDX_W-1:0] acc_set;
    logic [XLC_IDX_W-1:0] fl_set;
    xlc_set_t acc_ways;
    xlc_set_t fl_ways;
    logic [XLC_WAYS-1:0] acc_match;
    logic [XLC_WAYS-1:0] fl_match;
    logic [XLC_WAY_W-1:0] acc_hit_way;
    logic [XLC_WAY_W-1:0] victim_way;
    logic [XLC_WAYS-1:0] acc_valid;

    function automatic logic [XLC_IDX_W-1:0] set_of(input logic [XLC_LA_W-1:0] la,
                                                   input logic big);
        set_of = big ? la[XLC_IDX_LSB_8K +: XLC_IDX_W]
                     : la[XLC_IDX_LSB_4K +: XLC_IDX_W]; // RQ13
    endfunction : set_of

    assign acc_set = set_of(la_i, page_8k_i);
    assign fl_set = set_of(flush_la_i, page_8k_i);

    always_comb begin
        for (int w = 0; w < XLC_WAYS; w++) begin
            acc_ways[w] = cur_ff.ent[{acc_set, XLC_WAY_W'(w)}];
            fl_ways[w] = cur_ff.ent[{fl_set, XLC_WAY_W'(w)}];
            acc_valid[w] = acc_ways[w].valid;
        end
    end

    // Combinational lookup overlaps cache indexing
    xlc_tag_match u_acc_match ( // RQ20
        .ways_i(acc_ways),
        .tag_i(la_i[XLC_TAG_LSB +: XLC_TAG_W]),
        .priv_i(super_i),
        .page_8k_i(page_8k_i),
        .match_o(acc_match),
        .way_o(acc_hit_way)
    );

    xlc_tag_match u_fl_match (
        .ways_i(fl_ways),
        .tag_i(flush_la_i[XLC_TAG_LSB +: XLC_TAG_W]),
        .priv_i(flush_super_i),
        .page_8k_i(page_8k_i),
        .match_o(fl_match),
        .way_o()
    );

    xlc_victim u_victim (
        .valid_i(acc_valid),
        .ctr_i(cur_ff.ctr),
        .way_o(victim_way)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    xlc_entry_t hit_ent;
    logic [XLC_PA_W-1:0] hit_pa;
    logic any_flush;

    assign hit_ent = acc_ways[acc_hit_way];
    assign any_flush = translation_flush_op_i || flush_all_op_i;

    always_comb begin
        hit_pa = hit_ent.phys;
        if (page_8k_i) begin
            hit_pa[0] = la_i[XLC_PA_LSB]; // RQ16
        end
    end

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        nxt_cur.miss = 1'b0;
        nxt_cur.acc_err = 1'b0;
        nxt_cur.bus_err = 1'b0;
        nxt_cur.retry = 1'b0;
        nxt_cur.srch = 1'b0;

        case (cur_ff.state)
            XLC_IDLE: begin
                if (any_flush) begin
                    // Flush takes the cycle; a request waits behind it
                    for (int e = 0; e < XLC_ENTRIES; e++) begin
                        if ((flush_all_op_i
                                || ((XLC_IDX_W'(e >> XLC_WAY_W) == fl_set)
                                    && fl_match[e % XLC_WAYS]))
                            && !(flush_nonglobal_i && cur_ff.ent[e].global_pg)) begin // RQ4
                            nxt_cur.ent[e].valid = 1'b0; // RQ10
                        end
                    end
                end else if (req_i && cur_ff.ready && translate_en_i) begin
                    // Wraps explicitly from XLC_CTR_MAX back to XLC_CTR_RESET
                    nxt_cur.ctr = (cur_ff.ctr == XLC_CTR_MAX) ? XLC_CTR_RESET
                                : cur_ff.ctr + 2'h1; // RQ19 RQ22
                    nxt_cur.p_super = super_i;
                    nxt_cur.s_la = la_i;
                    nxt_cur.s_super = super_i;
                    nxt_cur.s_write = write_i;
                    nxt_cur.s_root = (super_i && !alt_space_move_i)
                                   ? supervisor_root_ptr_i : user_root_ptr_i; // RQ21
                    if (|acc_match) begin
                        if (!hit_ent.resident) begin
                            nxt_cur.bus_err = 1'b1; // RQ7
                        end else if (hit_ent.super_only && !super_i) begin
                            nxt_cur.acc_err = 1'b1; // RQ8
                        end else if (write_i && hit_ent.write_prot) begin
                            nxt_cur.acc_err = 1'b1; // RQ11 RQ12
                        end else if (write_i && !hit_ent.modified) begin
                            // Suspend the write and refresh this very entry
                            nxt_cur.miss = 1'b1; // RQ6
                            nxt_cur.srch = 1'b1;
                            nxt_cur.p_slot = {acc_set, acc_hit_way};
                            nxt_cur.ready = 1'b0;
                            nxt_cur.state = XLC_SEARCH;
                        end else begin
                            nxt_cur.done = 1'b1; // RQ14
                            nxt_cur.pa = hit_pa;
                            nxt_cur.cm = hit_ent.cache_policy_field; // RQ2
                            nxt_cur.upa = ext_bus_i ? hit_ent.user_attr : 2'h0; // RQ9
                        end
                    end else begin
                        nxt_cur.miss = 1'b1; // RQ15
                        nxt_cur.srch = 1'b1;
                        nxt_cur.p_slot = {acc_set, victim_way}; // RQ18
                        nxt_cur.ready = 1'b0;
                        nxt_cur.state = XLC_SEARCH;
                    end
                end else if (req_i && cur_ff.ready) begin
                    // Translation off: logical page passes through
                    nxt_cur.done = 1'b1;
                    nxt_cur.pa = la_i[XLC_PA_LSB +: XLC_PA_W];
                    nxt_cur.cm = XLC_CM_WRITE_THROUGH;
                    nxt_cur.upa = 2'h0;
                end
            end
            XLC_SEARCH: begin
                if (walk_done_i) begin
                    nxt_cur.ent[cur_ff.p_slot].valid = 1'b1; // RQ10
                    nxt_cur.ent[cur_ff.p_slot].privilege_tag_bit = cur_ff.p_super; // RQ3
                    nxt_cur.ent[cur_ff.p_slot].tag = cur_ff.s_la[XLC_TAG_LSB +: XLC_TAG_W];
                    nxt_cur.ent[cur_ff.p_slot].phys = walk_phys_i;
                    nxt_cur.ent[cur_ff.p_slot].cache_policy_field = walk_cache_policy_field_i;
                    nxt_cur.ent[cur_ff.p_slot].user_attr = walk_user_attr_i;
                    nxt_cur.ent[cur_ff.p_slot].global_pg = walk_global_i;
                    nxt_cur.ent[cur_ff.p_slot].super_only = walk_super_only_i; // RQ8
                    nxt_cur.ent[cur_ff.p_slot].write_prot = walk_write_prot_i; // RQ11
                    nxt_cur.ent[cur_ff.p_slot].modified = walk_modified_i; // RQ6
                    nxt_cur.ent[cur_ff.p_slot].resident =
                        !walk_nonresident_i && !walk_tea_i; // RQ7
                    nxt_cur.retry = 1'b1; // RQ15
                    nxt_cur.ready = 1'b1;
                    nxt_cur.state = XLC_IDLE;
                end
            end
            default: begin
                nxt_cur.state = XLC_IDLE;
                nxt_cur.ready = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset clears entries for determinism

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cur_ff <= '0;
            cur_ff.state <= XLC_IDLE;
            cur_ff.ready <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the register

    assign ready_o = cur_ff.ready;
    assign done_o = cur_ff.done;
    assign miss_o = cur_ff.miss;
    assign access_error_o = cur_ff.acc_err;
    assign bus_error_o = cur_ff.bus_err;
    assign retry_o = cur_ff.retry;
    assign phys_addr_o = cur_ff.pa;
    assign cache_policy_field_o = cur_ff.cm;
    assign user_attr_out_zero_o = cur_ff.upa[0];
    assign user_attr_out_one_o = cur_ff.upa[1];
    assign search_req_o = cur_ff.srch;
    assign search_root_o = cur_ff.s_root;
    assign search_la_o = cur_ff.s_la;
    assign search_super_o = cur_ff.s_super;
    assign search_write_o = cur_ff.s_write;

endmodule : xlc_cache

`default_nettype wire

// ==== bench/xlc_cache_checker.sv ====
/*
 * Port assertions for the translation lookaside cache.
 * Assumes the cache top module, one clock and a synchronous low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module xlc_cache_checker
    import xlc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Inputs watched
    input wire logic translate_en_i,
    input wire logic page_8k_i,
    input wire logic [XLC_LA_W-1:0] supervisor_root_ptr_i,
    input wire logic [XLC_LA_W-1:0] user_root_ptr_i,
    input wire logic req_i,
    input wire logic [XLC_LA_W-1:0] la_i,
    input wire logic super_i,
    input wire logic alt_space_move_i,
    input wire logic ext_bus_i,
    input wire logic translation_flush_op_i,
    input wire logic flush_all_op_i,
    input wire logic walk_done_i,
    // Outputs watched
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic miss_o,
    input wire logic access_error_o,
    input wire logic bus_error_o,
    input wire logic retry_o,
    input wire logic [XLC_PA_W-1:0] phys_addr_o,
    input wire logic [1:0] cache_policy_field_o,
    input wire logic user_attr_out_zero_o,
    input wire logic user_attr_out_one_o,
    input wire logic search_req_o,
    input wire logic [XLC_LA_W-1:0] search_root_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////
    sequence s_taken;
        req_i && ready_o && !translation_flush_op_i && !flush_all_op_i;
    endsequence
    sequence s_done_8k;
        s_taken ##0 (translate_en_i && page_8k_i) ##1 done_o;
    endsequence
    sequence s_done_local;
        s_taken ##0 !ext_bus_i ##1 done_o;
    endsequence
    ////////////////////////////////////////////////////////////
    chk_one_answer: assert property (s_taken |=>
        $onehot({done_o, access_error_o, bus_error_o, miss_o})) else $error("answer count wrong");
    chk_miss_search: assert property (miss_o |-> search_req_o && !ready_o)
        else $error("miss without search");
    chk_retry_bound: assert property (miss_o |-> ##[1:300] retry_o)
        else $error("no retry after miss");
    chk_ready_hold: assert property (miss_o |=> (!ready_o until retry_o))
        else $error("ready during search");
    chk_walk_retry: assert property (walk_done_i |=> retry_o && ready_o)
        else $error("no retry after search end");
    chk_root_pick: assert property (search_req_o |-> search_root_o ==
        (($past(super_i) && !$past(alt_space_move_i)) ? $past(supervisor_root_ptr_i)
        : $past(user_root_ptr_i))) else $error("wrong root pointer");
    chk_pass_thru: assert property (s_taken ##0 !translate_en_i |=> done_o &&
        phys_addr_o == $past(la_i[31:12]) && cache_policy_field_o == 2'h0 &&
        !user_attr_out_zero_o && !user_attr_out_one_o) else $error("pass-through wrong");
    chk_bit12_pass: assert property (s_done_8k |-> phys_addr_o[0] == $past(la_i[12]))
        else $error("bit 12 not passed");
    chk_attr_gate: assert property (s_done_local |->
        !user_attr_out_zero_o && !user_attr_out_one_o) else $error("attributes without bus");
endmodule : xlc_cache_checker

bind xlc_cache xlc_cache_checker u_chk (.sys_clk_i, .rstn_i, .translate_en_i, .page_8k_i,
    .supervisor_root_ptr_i, .user_root_ptr_i, .req_i, .la_i, .super_i, .alt_space_move_i,
    .ext_bus_i, .translation_flush_op_i, .flush_all_op_i, .walk_done_i, .ready_o, .done_o,
    .miss_o, .access_error_o, .bus_error_o, .retry_o, .phys_addr_o, .cache_policy_field_o,
    .user_attr_out_zero_o, .user_attr_out_one_o, .search_req_o, .search_root_o);
`default_nettype wire

// ==== bench/xlc_walk_model.sv ====
/*
 * Search engine model: one done pulse per search after a set delay.
 * Assumes the bench sets the answer before the search ends.
 */
`timescale 1ns/1ps
`default_nettype none
module xlc_walk_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Request and prepared answer
    input wire logic search_req_i,
    input wire logic [3:0] delay_i,
    input wire logic [29:0] ans_i,
    // Search answer
    output logic walk_done_o,
    output logic [29:0] walk_o
);
    logic busy_ff;
    logic [3:0] cnt_ff;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            {busy_ff, cnt_ff, walk_done_o, walk_o} <= '0;
        end else begin
            walk_done_o <= 1'b0;
            // Fields released: toggle so stale values never look valid
            walk_o <= ~walk_o;
            if (search_req_i) begin
                busy_ff <= 1'b1;
                cnt_ff <= delay_i;
            end else if (busy_ff && cnt_ff == 4'h0) begin
                busy_ff <= 1'b0;
                walk_done_o <= 1'b1;
                walk_o <= ans_i;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule : xlc_walk_model
`default_nettype wire

// ==== bench/test_xlc_cache.sv ====
/*
 * Self-checking bench for the lookaside cache.
 * Assumes the search model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module test_xlc_cache;
    import xlc_pkg::*;
    logic sys_clk_i, rstn_i, translate_en_i, page_8k_i, req_i, super_i, write_i, alt_mv;
    logic ext_bus_i, fl_one, fl_all, fl_ng, walk_done, ready_o, done_o, miss_o, acc_o;
    logic bus_o, retry_o, srq, s_sup, s_wr, ua0, ua1;
    logic [31:0] la_i, fl_la, s_root, s_la;
    logic [19:0] pa_o;
    logic [1:0] cm_o;
    logic [29:0] walk_w, ans;
    logic [3:0] delay, r;
    int miscompares, n_checks, i;
    ////////////////////////////////////////////////////////////
    xlc_cache uut (.sys_clk_i, .rstn_i, .translate_en_i, .page_8k_i,
        .supervisor_root_ptr_i(32'h0000_5000), .user_root_ptr_i(32'h0000_9000), .req_i,
        .la_i, .super_i, .write_i, .alt_space_move_i(alt_mv), .ext_bus_i,
        .translation_flush_op_i(fl_one), .flush_all_op_i(fl_all), .flush_nonglobal_i(fl_ng),
        .flush_la_i(fl_la), .flush_super_i(1'b0), .walk_done_i(walk_done),
        .walk_phys_i(walk_w[29:10]), .walk_cache_policy_field_i(walk_w[9:8]),
        .walk_user_attr_i(walk_w[7:6]), .walk_global_i(walk_w[5]),
        .walk_super_only_i(walk_w[4]), .walk_write_prot_i(walk_w[3]),
        .walk_modified_i(walk_w[2]), .walk_nonresident_i(walk_w[1]), .walk_tea_i(walk_w[0]),
        .ready_o, .done_o, .miss_o, .access_error_o(acc_o), .bus_error_o(bus_o), .retry_o,
        .phys_addr_o(pa_o),
        .cache_policy_field_o(cm_o), .user_attr_out_zero_o(ua0), .user_attr_out_one_o(ua1),
        .search_req_o(srq), .search_root_o(s_root), .search_la_o(s_la),
        .search_super_o(s_sup), .search_write_o(s_wr));
    xlc_walk_model u_walk (.sys_clk_i, .rstn_i, .search_req_i(srq),
        .delay_i(delay), .ans_i(ans), .walk_done_o(walk_done), .walk_o(walk_w));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    ////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic cmp_flags(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %b want %b", $time, got, exp);
        end
    endtask : cmp_flags
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic stall;
        miscompares++;
        $display("BAD %0t no answer", $time);
        complete_run();
    endtask : stall
    task automatic tick;
        @(posedge sys_clk_i);
        #5;
    endtask : tick
    // Keep chains a second request back to back
    task automatic access(input logic [31:0] la, input logic sup, input logic wr,
        input logic keep, output logic [3:0] res);
        la_i = la;
        super_i = sup;
        write_i = wr;
        req_i = 1'b1;
        for (int n = 0; n < 100 && !ready_o; n++) tick();
        if (!ready_o) stall();
        tick();
        req_i = keep;
        res = {done_o, acc_o, bus_o, miss_o};
        for (int n = 0; n < 100 && res[0] && !retry_o; n++) tick();
        if (res[0] && !retry_o) stall();
    endtask : access
    task automatic rd(input logic [31:0] la, output logic [3:0] res);
        access(la, 1'b0, 1'b0, 1'b0, res);
    endtask : rd
    task automatic load(input logic [31:0] la, input logic sup, input logic wr,
        input logic [29:0] a, output logic [3:0] res);
        ans = a;
        access(la, sup, wr, 1'b0, res);
        cmp_flags(res, 4'h1);
        cmp_word(s_root, (sup && !alt_mv) ? 32'h0000_5000 : 32'h0000_9000);
        cmp_word(s_la, la);
        cmp_flags({3'h0, s_sup}, {3'h0, sup});
        access(la, sup, wr, 1'b0, res);
    endtask : load
    function automatic logic [29:0] mk(input logic [19:0] pa, input logic [1:0] cm,
        input logic [5:0] fl);
        return {pa, cm, 2'h2, fl};
    endfunction : mk
    ////////////////////////////////////////////////////////////
    initial begin
        {rstn_i, translate_en_i, page_8k_i, req_i, super_i, write_i, alt_mv} = 7'h0;
        {ext_bus_i, fl_one, fl_all, fl_ng, la_i, fl_la, ans} = 'h0;
        miscompares = 0;
        n_checks = 0;
        delay = 4'h2;
        repeat (4) tick();
        rstn_i = 1'b1;
        cmp_word({27'h0, ready_o, done_o, acc_o, bus_o, miss_o}, 32'h10);
        rd(32'h1234_5678, r);
        cmp_word({12'h0, pa_o}, 32'h12345);
        translate_en_i = 1'b1;
        // Every policy code, each in its own set
        for (i = 0; i < 4; i++) begin
            load({16'h0001, i[3:0], 12'h0}, 1'b0, 1'b0, mk(20'hA0000, i[1:0], 6'h04), r);
            cmp_flags(r, 4'h8);
            cmp_word({30'h0, cm_o}, 32'(i));
            cmp_word({30'h0, ua1, ua0}, 32'h0);
        end
        ext_bus_i = 1'b1;
        access(32'h0001_3000, 1'b0, 1'b0, 1'b1, r);
        cmp_word({ua1, ua0, 26'h0, r}, 32'h8000_0008);
        access(32'h0001_3000, 1'b1, 1'b0, 1'b0, r);
        cmp_flags(r, 4'h1);
        rd(32'h0000_3000, r);
        cmp_flags(r, 4'h1);
        alt_mv = 1'b1;
        delay = 4'h0;
        load(32'h0002_5000, 1'b1, 1'b0, mk(20'h00005, 2'h0, 6'h04), r);
        alt_mv = 1'b0;
        delay = 4'h9;
        load(32'h0003_6000, 1'b0, 1'b0, mk(20'h00006, 2'h0, 6'h14), r);
        cmp_flags(r, 4'h4);
        load(32'h0003_7000, 1'b1, 1'b1, mk(20'h00007, 2'h0, 6'h0C), r);
        cmp_flags(r, 4'h4);
        access(32'h0003_7000, 1'b1, 1'b0, 1'b0, r);
        cmp_flags(r, 4'h8);
        load(32'h0003_8000, 1'b0, 1'b0, mk(20'h00008, 2'h0, 6'h00), r);
        ans = mk(20'h00008, 2'h0, 6'h04);
        access(32'h0003_8000, 1'b0, 1'b1, 1'b0, r);
        cmp_flags({r[3:1], s_wr}, 4'h1);
        access(32'h0003_8000, 1'b0, 1'b1, 1'b0, r);
        cmp_flags(r, 4'h8);
        load(32'h0003_9000, 1'b0, 1'b0, mk(20'h00009, 2'h0, 6'h06), r);
        cmp_flags(r, 4'h2);
        load(32'h0003_A000, 1'b0, 1'b0, mk(20'h0000A, 2'h0, 6'h05), r);
        cmp_flags(r, 4'h2);
        delay = 4'h1;
        load(32'h0004_B000, 1'b0, 1'b0, mk(20'h0000B, 2'h0, 6'h24), r);
        load(32'h0004_C000, 1'b0, 1'b0, mk(20'h0000C, 2'h0, 6'h04), r);
        {fl_all, fl_ng} = 2'h3;
        tick();
        {fl_all, fl_ng} = 2'h0;
        rd(32'h0004_B000, r);
        cmp_flags(r, 4'h8);
        rd(32'h0004_C000, r);
        cmp_flags(r, 4'h1);
        {fl_one, fl_la} = {1'b1, 32'h0004_B000};
        tick();
        fl_one = 1'b0;
        rd(32'h0004_B000, r);
        cmp_flags(r, 4'h1);
        // Four tags into one empty set must all stay resident
        for (i = 0; i < 4; i++) load({16'h0010 + i[15:0], 16'hD000}, 1'b0, 1'b0, ans, r);
        for (i = 0; i < 4; i++) begin
            rd({16'h0010 + i[15:0], 16'hD000}, r);
            cmp_flags(r, 4'h8);
        end
        translate_en_i = 1'b0;
        page_8k_i = 1'b1;
        fl_all = 1'b1;
        tick();
        fl_all = 1'b0;
        translate_en_i = 1'b1;
        load(32'h0005_E000, 1'b0, 1'b0, mk(20'h12341, 2'h0, 6'h04), r);
        cmp_word({12'h0, pa_o}, 32'h12340);
        rd(32'h0005_F000, r);
        cmp_flags(r, 4'h8);
        cmp_word({12'h0, pa_o}, 32'h12341);
        complete_run();
    end
endmodule : test_xlc_cache
`default_nettype wire
